/* src/csu_pkg.sv */
// constants, offsets and types shared by the compacted save unit
package csu_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] CSU_OFF_CTRL = 8'h00;
	localparam logic [7:0] CSU_OFF_STATUS = 8'h04;
	localparam logic [7:0] CSU_OFF_MODE = 8'h08;
	localparam logic [7:0] CSU_OFF_SIMD = 8'h0c;
	localparam logic [7:0] CSU_OFF_BANK = 8'h10;
	localparam logic [7:0] CSU_OFF_BANK_END = 8'h50;
	localparam logic [7:0] CSU_OFF_REC = 8'h50;
	localparam logic [7:0] CSU_OFF_HDR_LO = 8'h58;
	localparam logic [7:0] CSU_OFF_HDR_HI = 8'h5c;
	localparam logic [7:0] CSU_OFF_STM_LO = 8'h60;
	localparam logic [7:0] CSU_OFF_STM_HI = 8'h64;
	// 64-bit bank slots
	localparam int CSU_NBANK = 8;
	localparam logic [2:0] CSU_B_UE = 3'h0;
	localparam logic [2:0] CSU_B_SE = 3'h1;
	localparam logic [2:0] CSU_B_MASK = 3'h2;
	localparam logic [2:0] CSU_B_AREA = 3'h3;
	localparam logic [2:0] CSU_B_INUSE = 3'h4;
	localparam logic [2:0] CSU_B_MOD = 3'h5;
	localparam logic [2:0] CSU_B_RADDR = 3'h6;
	localparam logic [2:0] CSU_B_RCOMP = 3'h7;
	// field positions
	localparam int CSU_CTRL_START = 0;
	localparam int CSU_CTRL_PRIV = 1;
	localparam int CSU_CTRL_STDREC = 2;
	localparam int CSU_MODE_OS = 0;
	localparam int CSU_MODE_TS = 3;
	localparam int CSU_MODE_AM = 4;
	localparam int CSU_MODE_AC = 5;
	localparam int CSU_MODE_CPL = 6;
	localparam int CSU_MODE_NR = 8;
	localparam int CSU_REC_NR = 2;
	// reset values
	localparam logic [31:0] CSU_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] CSU_SIMD_RST = 32'h0000_1f80;
	localparam logic [63:0] CSU_BANK_RST = 64'h0;
	localparam logic [2:0] CSU_REC_RST = 3'h0;
	// save area layout and constants
	localparam logic [31:0] CSU_SIMD_INIT = 32'h0000_1f80;
	localparam logic [63:0] CSU_HDR_ST_OFF = 64'h200;
	localparam logic [63:0] CSU_HDR_CP_OFF = 64'h208;
	localparam logic [63:0] CSU_LEG_BASE = 64'h0;
	localparam logic [63:0] CSU_EXT_BASE = 64'h240;
	localparam logic [5:0] CSU_LAST_COMP = 6'h3e;
	localparam logic [1:0] CSU_USER_CPL = 2'h3;
	localparam logic [2:0] CSU_SIZE_WORD = 3'h2;
	// fault codes
	typedef enum logic [2:0] {
		CSU_F_NONE = 3'h0,
		CSU_F_UD = 3'h1,
		CSU_F_NM = 3'h2,
		CSU_F_GP = 3'h3,
		CSU_F_AC = 3'h4
	} csu_fault_e;
	// engine states, gray along the save path
	typedef enum logic [2:0] {
		CSU_IDLE = 3'h0,
		CSU_CHECK = 3'h1,
		CSU_HST = 3'h3,
		CSU_HCP = 3'h2,
		CSU_STORE = 3'h6,
		CSU_DONE = 3'h7
	} csu_state_e;
endpackage : csu_pkg

/* src/csu_op_if.sv */
// operand and result bundle between the engine and its decoders
interface csu_op_if;
	import csu_pkg::*;
	logic priv;
	logic os_en, ts, am, ac, nr, rnr;
	logic [1:0] current_privilege_level, rcpl;
	logic [31:0] simd;
	logic [63:0] ue, se, mask, area, inuse, modif, raddr, rcomp;
	csu_fault_e fault;
	logic [63:0] requested_component_bitmap, state_bm, comp_bm, store_bm;
	logic mod_ok;
	modport ctl (output priv, os_en, ts, am, ac, nr, rnr, current_privilege_level, rcpl, simd, ue, se, mask,
		area, inuse, modif, raddr, rcomp, input fault, requested_component_bitmap, state_bm, comp_bm, store_bm, mod_ok);
	modport chk (input priv, os_en, ts, am, ac, current_privilege_level, area, output fault);
	modport bmp (input priv, nr, rnr, current_privilege_level, rcpl, simd, ue, se, mask, area, inuse, modif,
		raddr, rcomp, output requested_component_bitmap, state_bm, comp_bm, store_bm, mod_ok);
endinterface : csu_op_if

/* src/csu_fault_chk.sv */
// ordered fault check for both save variants
module csu_fault_chk
	import csu_pkg::*;
(
	csu_op_if.chk op
);
	// priority: invalid opcode, then not available, then protection
	always_comb
	begin
		if (!op.os_en)
			op.fault = CSU_F_UD;
		else if (op.ts)
			op.fault = CSU_F_NM;
		else if (op.priv && (op.current_privilege_level != 2'h0))
			op.fault = CSU_F_GP;
		else if (op.area[5:0] != 6'h0)
		begin
			// user variant takes the alignment-check form when it is armed
			if (!op.priv && op.am && (op.current_privilege_level == CSU_USER_CPL) && op.ac)
				op.fault = CSU_F_AC;
			else
				op.fault = CSU_F_GP;
		end
		else
			op.fault = CSU_F_NONE;
	end
endmodule : csu_fault_chk

/* src/csu_bitmap.sv */
// requested, header and store bitmaps for the compacted saves
module csu_bitmap
	import csu_pkg::*;
(
	csu_op_if.bmp op
);
	logic simd_dirty; // control/status off its init value while requested
	logic [63:0] keep; // components the modified filter lets through
	always_comb
	begin
		// user form sees only user enables, privileged adds supervisor ones
		if (op.priv)
			op.requested_component_bitmap = op.mask & (op.ue | op.se);
		else
			op.requested_component_bitmap = op.mask & op.ue;
		simd_dirty = op.requested_component_bitmap[1] && (op.simd != CSU_SIMD_INIT);
		// unrequested bits written as zero, requested ones follow in-use
		op.state_bm = op.requested_component_bitmap & op.inuse;
		op.state_bm[1] = op.state_bm[1] | simd_dirty;
		op.comp_bm = {1'b1, op.requested_component_bitmap[62:0]};
		// modified filter only for the privileged form with a matching record
		op.mod_ok = op.priv && (op.rcpl == op.current_privilege_level) && (op.rnr == op.nr) &&
			(op.raddr == op.area) && (op.rcomp == op.comp_bm);
		keep = op.mod_ok ? op.modif : {64{1'b1}};
		op.store_bm = op.requested_component_bitmap & op.inuse & keep;
		// control/status travels with component 1 only, never with bit 2
		op.store_bm[1] = op.store_bm[1] | simd_dirty;
		op.store_bm[63] = 1'b0;
	end
endmodule : csu_bitmap

/* src/csu_save_unit.sv */
// compacted state save engine with its AHB-Lite register slave
module csu_save_unit
	import csu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic mem_req,
	output logic [63:0] mem_addr,
	output logic [63:0] mem_data,
	output logic mem_kind,
	output logic [5:0] mem_comp,
	input wire logic mem_ack
);
	csu_op_if op(); // operands to and results from the decoders

	// bus and configuration state
	logic a_valid_reg, a_valid_next; // data phase of a taken write or read
	logic a_write_reg, a_write_next;
	logic [7:0] a_addr_reg, a_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hready_reg, hresp_reg; // zero-wait slave, always OKAY
	logic priv_reg, priv_next; // selected variant
	logic start_reg, start_next; // one-cycle launch pulse
	logic [31:0] mode_reg, mode_next;
	logic [31:0] simd_reg, simd_next;
	logic [2:0] rec_reg, rec_next; // record privilege and non-root
	logic [63:0] bank_reg [CSU_NBANK];
	logic [63:0] bank_next [CSU_NBANK];
	// engine state
	csu_state_e state_reg, state_next;
	logic [5:0] idx_reg, idx_next; // component being considered
	csu_fault_e fault_reg, fault_next;
	logic done_reg, done_next;
	logic modopt_reg, modopt_next; // modified filter used last run
	logic [63:0] hdr_reg, hdr_next; // header state value written
	logic [63:0] stm_reg, stm_next; // frozen store selection
	logic req_reg, req_next;
	logic [63:0] maddr_reg, maddr_next;
	logic [63:0] mdata_reg, mdata_next;
	logic kind_reg, kind_next;
	logic [5:0] comp_reg, comp_next;
	logic busy; // engine away from idle
	logic take; // address phase accepted this edge

	// bank slot decode, used for both reads and writes
	function automatic logic bank_hit(input logic [7:0] a);
		bank_hit = (a >= CSU_OFF_BANK) && (a < CSU_OFF_BANK_END);
	endfunction : bank_hit
	function automatic logic [2:0] bank_idx(input logic [7:0] a);
		bank_idx = a[5:3] - 3'h2;
	endfunction : bank_idx

	// operands come straight from the registers, frozen while busy
	assign op.priv = priv_reg;
	assign op.os_en = mode_reg[CSU_MODE_OS];
	assign op.ts = mode_reg[CSU_MODE_TS];
	assign op.am = mode_reg[CSU_MODE_AM];
	assign op.ac = mode_reg[CSU_MODE_AC];
	assign op.current_privilege_level = mode_reg[CSU_MODE_CPL +: 2];
	assign op.nr = mode_reg[CSU_MODE_NR];
	assign op.rcpl = rec_reg[1:0];
	assign op.rnr = rec_reg[CSU_REC_NR];
	assign op.simd = simd_reg;
	assign op.ue = bank_reg[CSU_B_UE];
	assign op.se = bank_reg[CSU_B_SE];
	assign op.mask = bank_reg[CSU_B_MASK];
	assign op.area = bank_reg[CSU_B_AREA];
	assign op.inuse = bank_reg[CSU_B_INUSE];
	assign op.modif = bank_reg[CSU_B_MOD];
	assign op.raddr = bank_reg[CSU_B_RADDR];
	assign op.rcomp = bank_reg[CSU_B_RCOMP];

	csu_fault_chk u_chk (
		.op(op.chk)
	);
	csu_bitmap u_bmp (
		.op(op.bmp)
	);

	assign busy = (state_reg != CSU_IDLE);
	assign take = hsel && hready && htrans[1] && (hsize == CSU_SIZE_WORD);

	// bus slave: read data is muxed in the address phase so it stands in the data phase
	always_comb
	begin
		a_valid_next = take;
		a_write_next = hwrite;
		a_addr_next = haddr[7:0];
		hrdata_next = 32'h0;
		priv_next = priv_reg;
		start_next = 1'b0;
		mode_next = mode_reg;
		simd_next = simd_reg;
		rec_next = rec_reg;
		for (int k = 0; k < CSU_NBANK; k++)
			bank_next[k] = bank_reg[k];
		// reads; unmapped words read zero
		if (take && !hwrite)
		begin
			if (bank_hit(haddr[7:0]))
			begin
				if (haddr[2])
					hrdata_next = bank_reg[bank_idx(haddr[7:0])][63:32];
				else
					hrdata_next = bank_reg[bank_idx(haddr[7:0])][31:0];
			end
			else
			begin
				case (haddr[7:0])
					CSU_OFF_CTRL: hrdata_next = {30'h0, priv_reg, 1'b0};
					CSU_OFF_STATUS: hrdata_next = {26'h0, modopt_reg, fault_reg, done_reg, busy};
					CSU_OFF_MODE: hrdata_next = mode_reg;
					CSU_OFF_SIMD: hrdata_next = simd_reg;
					CSU_OFF_REC: hrdata_next = {29'h0, rec_reg};
					CSU_OFF_HDR_LO: hrdata_next = hdr_reg[31:0];
					CSU_OFF_HDR_HI: hrdata_next = hdr_reg[63:32];
					CSU_OFF_STM_LO: hrdata_next = stm_reg[31:0];
					CSU_OFF_STM_HI: hrdata_next = stm_reg[63:32];
					default: hrdata_next = 32'h0;
				endcase
			end
		end
		// writes in the data phase; ignored while a save runs
		if (a_valid_reg && a_write_reg && !busy)
		begin
			if (bank_hit(a_addr_reg))
			begin
				if (a_addr_reg[2])
					bank_next[bank_idx(a_addr_reg)][63:32] = hwdata;
				else
					bank_next[bank_idx(a_addr_reg)][31:0] = hwdata;
			end
			else
			begin
				case (a_addr_reg)
					CSU_OFF_CTRL:
					begin
						priv_next = hwdata[CSU_CTRL_PRIV];
						start_next = hwdata[CSU_CTRL_START];
						// a standard restore leaves an all-zero compaction value
						if (hwdata[CSU_CTRL_STDREC])
							bank_next[CSU_B_RCOMP] = 64'h0;
					end
					CSU_OFF_MODE: mode_next = hwdata;
					CSU_OFF_SIMD: simd_next = hwdata;
					CSU_OFF_REC: rec_next = hwdata[2:0];
					default: ;
				endcase
			end
		end
	end

	// bus and configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			a_valid_reg <= 1'b0;
			a_write_reg <= 1'b0;
			a_addr_reg <= 8'h0;
			hrdata_reg <= 32'h0;
			hready_reg <= 1'b1;
			hresp_reg <= 1'b0;
			priv_reg <= 1'b0;
			start_reg <= 1'b0;
			mode_reg <= CSU_MODE_RST;
			simd_reg <= CSU_SIMD_RST;
			rec_reg <= CSU_REC_RST;
			for (int k = 0; k < CSU_NBANK; k++)
				bank_reg[k] <= CSU_BANK_RST;
		end
		else
		begin
			a_valid_reg <= a_valid_next;
			a_write_reg <= a_write_next;
			a_addr_reg <= a_addr_next;
			hrdata_reg <= hrdata_next;
			hready_reg <= 1'b1;
			hresp_reg <= 1'b0;
			priv_reg <= priv_next;
			start_reg <= start_next;
			mode_reg <= mode_next;
			simd_reg <= simd_next;
			rec_reg <= rec_next;
			for (int k = 0; k < CSU_NBANK; k++)
				bank_reg[k] <= bank_next[k];
		end
	end

	// save engine: check, two header writes, then one pass over components
	always_comb
	begin
		logic adv;
		adv = 1'b0;
		state_next = state_reg;
		idx_next = idx_reg;
		fault_next = fault_reg;
		done_next = done_reg;
		modopt_next = modopt_reg;
		hdr_next = hdr_reg;
		stm_next = stm_reg;
		req_next = req_reg;
		maddr_next = maddr_reg;
		mdata_next = mdata_reg;
		kind_next = kind_reg;
		comp_next = comp_reg;
		case (state_reg)
			CSU_IDLE:
			begin
				if (start_reg)
				begin
					state_next = CSU_CHECK;
					done_next = 1'b0;
					fault_next = CSU_F_NONE;
					modopt_next = 1'b0; // a faulting run must not show a stale filter flag
				end
			end
			CSU_CHECK:
			begin
				// every fault is known here, before the first write leaves
				if (op.fault != CSU_F_NONE)
				begin
					fault_next = op.fault;
					state_next = CSU_DONE;
				end
				else
				begin
					hdr_next = op.state_bm;
					stm_next = op.store_bm;
					modopt_next = op.mod_ok;
					// header state field is written blind, no read first
					req_next = 1'b1;
					maddr_next = op.area + CSU_HDR_ST_OFF;
					mdata_next = op.state_bm;
					kind_next = 1'b0;
					comp_next = 6'h0;
					state_next = CSU_HST;
				end
			end
			CSU_HST:
			begin
				// only the two bitmap words of the header are touched
				if (mem_ack)
				begin
					maddr_next = op.area + CSU_HDR_CP_OFF;
					mdata_next = op.comp_bm;
					state_next = CSU_HCP;
				end
			end
			CSU_HCP:
			begin
				if (mem_ack)
				begin
					req_next = 1'b0;
					idx_next = 6'h0;
					state_next = CSU_STORE;
				end
			end
			CSU_STORE:
			begin
				if (req_reg)
				begin
					if (mem_ack)
					begin
						req_next = 1'b0;
						adv = 1'b1;
					end
				end
				else if (stm_reg[idx_reg])
				begin
					// components 0 and 1 go to the legacy region
					req_next = 1'b1;
					kind_next = 1'b1;
					comp_next = idx_reg;
					mdata_next = 64'h0;
					if (idx_reg < 6'h2)
						maddr_next = op.area + CSU_LEG_BASE;
					else
						maddr_next = op.area + CSU_EXT_BASE;
				end
				else
					adv = 1'b1; // skipped: not requested, or by init or modified filter
				if (adv)
				begin
					if (idx_reg == CSU_LAST_COMP)
						state_next = CSU_DONE;
					else
						idx_next = idx_reg + 6'h1;
				end
			end
			CSU_DONE:
			begin
				done_next = 1'b1;
				state_next = CSU_IDLE;
			end
			default: state_next = CSU_IDLE;
		endcase
	end

	// engine registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= CSU_IDLE;
			idx_reg <= 6'h0;
			fault_reg <= CSU_F_NONE;
			done_reg <= 1'b0;
			modopt_reg <= 1'b0;
			hdr_reg <= 64'h0;
			stm_reg <= 64'h0;
			req_reg <= 1'b0;
			maddr_reg <= 64'h0;
			mdata_reg <= 64'h0;
			kind_reg <= 1'b0;
			comp_reg <= 6'h0;
		end
		else
		begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			fault_reg <= fault_next;
			done_reg <= done_next;
			modopt_reg <= modopt_next;
			hdr_reg <= hdr_next;
			stm_reg <= stm_next;
			req_reg <= req_next;
			maddr_reg <= maddr_next;
			mdata_reg <= mdata_next;
			kind_reg <= kind_next;
			comp_reg <= comp_next;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hready_reg;
	assign hresp = hresp_reg;
	assign mem_req = req_reg;
	assign mem_addr = maddr_reg;
	assign mem_data = mdata_reg;
	assign mem_kind = kind_reg;
	assign mem_comp = comp_reg;

	// checks on the fault code and on what the engine drives toward memory
	property p_ud;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_CHECK) && !mode_reg[CSU_MODE_OS] |=> (fault_reg == CSU_F_UD) && !req_reg;
	endproperty
	a_ud: assert property (p_ud) else $error("no invalid opcode fault");
	property p_nm;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_CHECK) && mode_reg[CSU_MODE_OS] && mode_reg[CSU_MODE_TS]
		|=> (fault_reg == CSU_F_NM);
	endproperty
	a_nm: assert property (p_nm) else $error("no not-available fault");
	property p_gp_cpl;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_CHECK) && op.os_en && !op.ts && priv_reg && (op.current_privilege_level != 2'h0)
		|=> (fault_reg == CSU_F_GP);
	endproperty
	a_gp_cpl: assert property (p_gp_cpl) else $error("privilege not refused");
	property p_nowrite;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_CHECK) && (op.fault != CSU_F_NONE) |=> !req_reg [*2];
	endproperty
	a_nowrite: assert property (p_nowrite) else $error("write after fault");
	property p_hdr_st;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_HST) && req_reg |-> (mdata_reg & ~op.requested_component_bitmap) == 64'h0;
	endproperty
	a_hdr_st: assert property (p_hdr_st) else $error("unrequested header bit set");
	property p_simd_hdr;
		@(posedge hclk) disable iff (!hresetn)
		(state_reg == CSU_HST) && req_reg && op.requested_component_bitmap[1] && (simd_reg != CSU_SIMD_INIT)
		|-> mdata_reg[1];
	endproperty
	a_simd_hdr: assert property (p_simd_hdr) else $error("header bit 1 not forced");
	property p_hdr_cp;
		@(posedge hclk) disable iff (!hresetn)
		$rose(state_reg == CSU_HCP) |-> mdata_reg[63] && (mdata_reg[62:0] ==
		(priv_reg ? (op.mask[62:0] & (op.ue[62:0] | op.se[62:0])) : (op.mask[62:0] & op.ue[62:0])));
	endproperty
	a_hdr_cp: assert property (p_hdr_cp) else $error("bad compaction header");
	property p_init;
		@(posedge hclk) disable iff (!hresetn)
		req_reg && kind_reg |-> op.inuse[comp_reg] || ((comp_reg == 6'h1) &&
		(simd_reg != CSU_SIMD_INIT));
	endproperty
	a_init: assert property (p_init) else $error("stored a component not in use");
	property p_mod;
		@(posedge hclk) disable iff (!hresetn)
		req_reg && kind_reg && modopt_reg |-> priv_reg && (op.modif[comp_reg] ||
		(comp_reg == 6'h1));
	endproperty
	a_mod: assert property (p_mod) else $error("stored an unmodified component");
endmodule : csu_save_unit

/* testbench/csu_mem_model.sv */
// behavioural save-area memory that acknowledges and logs write requests
module csu_mem_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic [3:0] delay,
	input wire logic [63:0] area,
	input wire logic mem_req,
	input wire logic [63:0] mem_addr,
	input wire logic [63:0] mem_data,
	input wire logic mem_kind,
	input wire logic [5:0] mem_comp,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt; // cycles the open request has waited
	logic [63:0] stored; // one bit per component that was stored
	logic [63:0] hst_seen; // header state value written
	logic [63:0] hcp_seen; // header compaction value written
	int nwr; // completed write requests
	int nhdr; // completed header writes
	int last_comp; // last component index stored
	logic seq_bad; // order, address or header field broken
	// ack after a programmable wait; ack is one cycle, never left high
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn || clr)
		begin
			mem_ack <= 1'b0;
			wait_cnt <= 4'h0;
			stored <= 64'h0;
			hst_seen <= 64'h0;
			hcp_seen <= 64'h0;
			nwr <= 0;
			nhdr <= 0;
			last_comp <= -1;
			seq_bad <= 1'b0;
		end
		else
		begin
			mem_ack <= 1'b0;
			if (mem_req && mem_ack)
			begin
				wait_cnt <= 4'h0;
				nwr <= nwr + 1;
				if (!mem_kind)
				begin
					// state field first, compaction second, nothing else
					if (nhdr == 0 && mem_addr == area + 64'h200)
						hst_seen <= mem_data;
					else if (nhdr == 1 && mem_addr == area + 64'h208)
						hcp_seen <= mem_data;
					else
						seq_bad <= 1'b1;
					nhdr <= nhdr + 1;
				end
				else
				begin
					// stores only after the header, rising index, right region
					if (nhdr != 2 || int'(mem_comp) <= last_comp || mem_comp > 6'h3e)
						seq_bad <= 1'b1;
					if (mem_addr != area + ((mem_comp < 6'h2) ? 64'h0 : 64'h240))
						seq_bad <= 1'b1;
					stored[mem_comp] <= 1'b1;
					last_comp <= int'(mem_comp);
				end
			end
			else if (mem_req && wait_cnt >= delay)
				mem_ack <= 1'b1;
			else if (mem_req)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : csu_mem_model

/* testbench/compacted_state_save_unit_test.sv */
// self-checking bench for the compacted state save unit
module compacted_state_save_unit_test import csu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
`define CSU_CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
	$display("wrong value %s exp %h got %h", what, exp, got); end end
	logic hclk = 1'b0;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic mem_req;
	logic [63:0] mem_addr;
	logic [63:0] mem_data;
	logic mem_kind;
	logic [5:0] mem_comp;
	logic mem_ack;
	logic clr; // clears the memory log between saves
	logic [3:0] mdelay; // memory answer delay
	logic [63:0] bk [CSU_NBANK]; // bench copy of the 64-bit bank
	logic [31:0] mode;
	logic [31:0] simd;
	logic [31:0] rec;
	int compares = 0;
	int bad_count = 0;
	int cycles = 0;
	// the one slave drives the bus hready
	csu_save_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_data(mem_data), .mem_kind(mem_kind), .mem_comp(mem_comp),
		.mem_ack(mem_ack));
	csu_mem_model mem (.hclk(hclk), .hresetn(hresetn), .clr(clr), .delay(mdelay),
		.area(bk[CSU_B_AREA]), .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data),
		.mem_kind(mem_kind), .mem_comp(mem_comp), .mem_ack(mem_ack));
	// 50 MHz clock
	always #10 hclk = ~hclk;
	// hang guard, far above the longest expected run
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// one single word transfer; entered just after a rising edge
	task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= CSU_SIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb_xfer
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb_xfer(1'b1, a, d, dummy);
	endtask : wr32
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		ahb_xfer(1'b0, a, 32'h0, d);
	endtask : rd32
	// clear the memory log; one edge of clr
	task automatic mclr();
		clr <= 1'b1;
		@(posedge hclk);
		clr <= 1'b0;
	endtask : mclr
	// load every operand register from the bench copy
	task automatic apply();
		wr32(CSU_OFF_MODE, mode);
		wr32(CSU_OFF_SIMD, simd);
		wr32(CSU_OFF_REC, rec);
		for (int i = 0; i < CSU_NBANK; i++)
		begin
			wr32(CSU_OFF_BANK + 8'(8 * i), bk[i][31:0]);
			wr32(CSU_OFF_BANK + 8'(8 * i + 4), bk[i][63:32]);
		end
		mclr();
	endtask : apply
	// start a save, wait for done, judge faults, header and stores
	task automatic check_save(input logic priv);
		logic [31:0] st;
		logic [63:0] requested_component_bitmap;
		logic [63:0] live;
		logic [63:0] sel;
		logic dirty;
		logic mod_ok;
		logic [2:0] flt;
		requested_component_bitmap = bk[CSU_B_MASK] & (bk[CSU_B_UE] | (priv ? bk[CSU_B_SE] : 64'h0));
		dirty = requested_component_bitmap[1] && (simd != CSU_SIMD_INIT);
		live = bk[CSU_B_INUSE] | {62'h0, dirty, 1'b0};
		mod_ok = priv && rec[1:0] == mode[7:6] && rec[2] == mode[8]
			&& bk[CSU_B_RADDR] == bk[CSU_B_AREA] && bk[CSU_B_RCOMP] == {1'b1, requested_component_bitmap[62:0]};
		sel = requested_component_bitmap & live & {1'b0, {63{1'b1}}};
		if (mod_ok)
			sel = sel & (bk[CSU_B_MOD] | {62'h0, dirty, 1'b0});
		if (!mode[0])
			flt = CSU_F_UD;
		else if (mode[3])
			flt = CSU_F_NM;
		else if (priv && mode[7:6] != 2'h0)
			flt = CSU_F_GP;
		else if (bk[CSU_B_AREA][5:0] != 6'h0)
			flt = (!priv && mode[4] && mode[5] && mode[7:6] == 2'h3) ? CSU_F_AC : CSU_F_GP;
		else
			flt = CSU_F_NONE;
		wr32(CSU_OFF_CTRL, {30'h0, priv, 1'b1});
		repeat (2) @(posedge hclk);
		do rd32(CSU_OFF_STATUS, st); while (st[1] !== 1'b1);
		`CSU_CHK("fault", flt, st[4:2])
		`CSU_CHK("mod used", flt == 3'h0 && mod_ok, st[5])
		if (flt != 3'h0)
			`CSU_CHK("writes", 0, mem.nwr)
		else
		begin
			`CSU_CHK("state hdr", requested_component_bitmap & live, mem.hst_seen)
			`CSU_CHK("comp hdr", {1'b1, requested_component_bitmap[62:0]}, mem.hcp_seen)
			`CSU_CHK("stores", sel, mem.stored)
			`CSU_CHK("order", 1'b0, mem.seq_bad)
			rd32(CSU_OFF_HDR_LO, st);
			`CSU_CHK("hdr reg", requested_component_bitmap[31:0] & live[31:0], st)
		end
	endtask : check_save
	// reset values and an unmapped place
	task automatic t_reset();
		logic [31:0] d;
		rd32(CSU_OFF_MODE, d);
		`CSU_CHK("mode rst", CSU_MODE_RST, d)
		rd32(CSU_OFF_SIMD, d);
		`CSU_CHK("simd rst", CSU_SIMD_RST, d)
		rd32(CSU_OFF_REC, d);
		`CSU_CHK("rec rst", 32'h0, d)
		rd32(CSU_OFF_BANK, d);
		`CSU_CHK("bank rst", 32'h0, d)
		wr32(8'h80, 32'hffff_ffff);
		@(posedge hclk);
		rd32(8'h80, d);
		`CSU_CHK("unmapped", 32'h0, d)
		`CSU_CHK("hresp", 1'b0, hresp)
		`CSU_CHK("hready", 1'b1, hreadyout)
		$display("test reset done");
	endtask : t_reset
	// each fault cause, the privilege case between the alignment ones, with no memory traffic
	task automatic t_faults();
		logic [31:0] fm [6] = '{32'h0, 32'h9, 32'h1, 32'hf1, 32'h41, 32'h31};
		logic [5:0] fa = 6'b111100;
		logic [5:0] fp = 6'b110000;
		bk = '{64'hff, 64'h0, 64'hff, 64'h1000, 64'hff, 64'hff, 64'h0, 64'h0};
		simd = CSU_SIMD_INIT;
		rec = 32'h0;
		for (int i = 0; i < 6; i++)
		begin
			mode = fm[i];
			bk[CSU_B_AREA] = fa[i] ? 64'h1008 : 64'h1000;
			apply();
			check_save(fp[i]);
		end
		$display("test faults done");
	endtask : t_faults
	// user save: dirty control/status, matching record ignored, slow memory
	task automatic t_user();
		mdelay <= 4'h3;
		mode = 32'hc1;
		simd = 32'h1f81;
		bk = '{64'h8000_0000_0000_0007, 64'h100, '1, 64'h2000, 64'h8000_0000_0000_0005,
			64'h0, 64'h2000, 64'h8000_0000_0000_0007};
		rec = 32'h3;
		apply();
		check_save(1'b0);
		bk[CSU_B_UE] = 64'h5;
		apply();
		check_save(1'b0);
		mdelay <= 4'h0;
		$display("test user done");
	endtask : t_user
	// privileged save with the modified filter, then a standard restore record
	task automatic t_priv();
		logic [31:0] d;
		mode = 32'h101;
		simd = CSU_SIMD_INIT;
		rec = 32'h4;
		bk = '{64'h3, 64'h4000_0000_0000_0100, '1, 64'h3000, '1, 64'h4000_0000_0000_0001,
			64'h3000, 64'hc000_0000_0000_0103};
		apply();
		check_save(1'b1);
		wr32(CSU_OFF_CTRL, 32'h4);
		@(posedge hclk);
		rd32(CSU_OFF_BANK + 8'h38, d);
		`CSU_CHK("rec comp", 32'h0, d)
		bk[CSU_B_RCOMP] = 64'h0;
		mclr();
		check_save(1'b1);
		bk[CSU_B_RCOMP] = 64'hc000_0000_0000_0103;
		rec = 32'h0;
		apply();
		check_save(1'b1);
		$display("test priv done");
	endtask : t_priv
	// reset, then the scenarios in turn
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		clr = 1'b0;
		mdelay = 4'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_faults();
		t_user();
		t_priv();
		end_sim();
	end
endmodule : compacted_state_save_unit_test
